// [rtl/quad_dac_serial_control.sv]
// Purpose: serial control logic of a quad 8-bit dac
// Assumes: link pins are sampled by i_core_clk through two flip-flops
// Notes: all link edges are found on the core clock; 64 ns link period gives 8 samples
// Overview of operation
// - chip select rise writes addressed input register
// - load strobe low keeps input register steady
// - load strobe low copies inputs to dac
// - dac registers transparent while strobe low
// - two select bits choose channel a..d
// - shutdown-all bit low powers down all
// - shutdown-selected bit low powers down one
// - shut-down channel output is not driven
// - shift on clock rise while selected
// - clear zeros input and dac registers
// - chip select does not block load strobe
`timescale 1ns/1ps
`default_nettype none
module quad_dac_serial_control (
    // core clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // serial link pins, asynchronous to the core clock
    input wire logic i_serial_clk,
    input wire logic i_chip_select_n,
    input wire logic i_serial_in_powerdown_pin,
    // control pins, asynchronous
    input wire logic i_dac_update_strobe_n,
    input wire logic i_async_zero_clear_n,
    // channel outputs a..d packed low to high
    output logic [31:0] o_dac_value,
    output logic [3:0] o_dac_drive_en,
    output logic [31:0] o_input_value,
    output logic [11:0] o_shift_reg
);
    // everything the block remembers: one register image and one next-value image
    typedef struct packed {
        logic [2:0] sclk_s1;
        logic [2:0] sclk_s2;
        logic [1:0] ctl_s1;
        logic [1:0] ctl_s2;
        logic sclk_prev;
        logic cs_prev;
        logic [11:0] shift_reg;
        logic [31:0] input_regs;
        logic [31:0] dac_regs;
        logic [3:0] power_down_control;
    } state_t;

    state_t st;
    state_t next_st;

    // channel decode shared by the data write and the selected shutdown
    function automatic logic chan_hit(input logic [1:0] code, input int ch);
        return code == 2'(ch);
    endfunction

    // link stage order: bit0 serial clock, bit1 chip select n, bit2 data
    logic sclk_sync;
    logic cs_n_sync;
    logic data_sync;
    // control stage order: bit0 update strobe n, bit1 zero clear n
    logic strobe_n_sync;
    logic clear_n_sync;
    // edge and event terms, all taken from the second sync stage
    logic sclk_rise;
    logic cs_rise;
    logic shift_event;
    logic word_event;
    logic [1:0] sel;

    assign sclk_sync = st.sclk_s2[0];
    assign cs_n_sync = st.sclk_s2[1];
    assign data_sync = st.sclk_s2[2];
    assign strobe_n_sync = st.ctl_s2[0];
    assign clear_n_sync = st.ctl_s2[1];
    assign sclk_rise = sclk_sync && !st.sclk_prev;
    assign cs_rise = cs_n_sync && !st.cs_prev;
    // a clock rise while deselected is dropped, so a stray clock between frames does no harm
    assign shift_event = !cs_n_sync && sclk_rise;
    // select rise with the clock low; a low strobe or clear refuses the word
    assign word_event = cs_rise && !sclk_sync && strobe_n_sync && clear_n_sync;
    assign sel = st.shift_reg[quad_dac_pkg::CHAN_SEL_HIGH_POS:quad_dac_pkg::CHAN_SEL_LOW_POS];

    // next-state logic; later blocks override earlier ones, so the clear wins
    always_comb begin
        next_st = st;
        // two flip-flops on every pin; clear is sampled, not truly asynchronous
        next_st.sclk_s1 = {i_serial_in_powerdown_pin, i_chip_select_n, i_serial_clk};
        next_st.sclk_s2 = st.sclk_s1;
        next_st.ctl_s1 = {i_async_zero_clear_n, i_dac_update_strobe_n};
        next_st.ctl_s2 = st.ctl_s1;
        // edge history, one sample behind the second stage
        next_st.sclk_prev = sclk_sync;
        next_st.cs_prev = cs_n_sync;
        // msb arrives first and enters at the bottom; surplus bits fall off the top
        if (shift_event) begin
            next_st.shift_reg = {st.shift_reg[quad_dac_pkg::WORD_BITS-2:0], data_sync};
        end
        // input registers move only on an accepted word or a clear, so a held strobe leaves them alone
        if (word_event) begin
            for (int ch = 0; ch < quad_dac_pkg::CHANNELS; ch++) begin
                if (chan_hit(sel, ch)) begin
                    next_st.input_regs[ch*quad_dac_pkg::DATA_BITS +: quad_dac_pkg::DATA_BITS] =
                        st.shift_reg[quad_dac_pkg::DATA_MSB_POS:0];
                end
            end
            // shutdown bits are active low; a word with both high wakes every channel
            for (int ch = 0; ch < quad_dac_pkg::CHANNELS; ch++) begin
                next_st.power_down_control[ch] = !st.shift_reg[quad_dac_pkg::SHUTDOWN_ALL_POS]
                    || (!st.shift_reg[quad_dac_pkg::SHUTDOWN_SEL_POS] && chan_hit(sel, ch));
            end
        end
        // strobe is level sensitive and ignores chip select; it passes the fresh input image
        if (!strobe_n_sync) begin
            next_st.dac_regs = next_st.input_regs;
        end
        // clear overrides a word or a strobe in the same cycle; the shift register is untouched
        if (!clear_n_sync) begin
            next_st.input_regs = {quad_dac_pkg::CHANNELS{quad_dac_pkg::REG_RESET}};
            next_st.dac_regs = {quad_dac_pkg::CHANNELS{quad_dac_pkg::REG_RESET}};
        end
    end

    // state register; reset loads every pin stage and edge history high so no false rising edge follows
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            st <= '{
                sclk_s1: quad_dac_pkg::SYNC_RESET,
                sclk_s2: quad_dac_pkg::SYNC_RESET,
                ctl_s1: quad_dac_pkg::CTL_SYNC_RESET,
                ctl_s2: quad_dac_pkg::CTL_SYNC_RESET,
                sclk_prev: quad_dac_pkg::EDGE_PREV_RESET,
                cs_prev: quad_dac_pkg::EDGE_PREV_RESET,
                shift_reg: quad_dac_pkg::SHIFT_RESET,
                input_regs: {quad_dac_pkg::CHANNELS{quad_dac_pkg::REG_RESET}},
                dac_regs: {quad_dac_pkg::CHANNELS{quad_dac_pkg::REG_RESET}},
                power_down_control: quad_dac_pkg::SHUTDOWN_RESET
            };
        end else begin
            st <= next_st;
        end
    end

    // outputs; a powered-down channel drops its drive enable
    assign o_dac_value = st.dac_regs;
    assign o_dac_drive_en = ~st.power_down_control;
    assign o_input_value = st.input_regs;
    assign o_shift_reg = st.shift_reg;

    // link side: shifting only on a selected clock rise
    shift_on_rise_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (!cs_n_sync && sclk_rise) |=> st.shift_reg == {$past(st.shift_reg[10:0]), $past(data_sync)})
        else $error("shift register did not advance");

    shift_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        cs_n_sync |=> $stable(st.shift_reg))
        else $error("shift register moved while deselected");

    // word side: the addressed slot takes the data byte and nothing else moves
    word_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (cs_rise && !sclk_sync && strobe_n_sync && clear_n_sync) |=>
        st.input_regs[$past(sel)*8 +: 8] == $past(st.shift_reg[7:0]))
        else $error("input register not written");

    route_one_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (cs_rise && !sclk_sync && strobe_n_sync && clear_n_sync) |=>
        ((st.input_regs ^ $past(st.input_regs)) & ~(32'h0000_00ff << ($past(sel) * 8))) == 32'h0)
        else $error("word touched another channel");

    refused_word_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (cs_rise && !strobe_n_sync && clear_n_sync) |=> $stable(st.input_regs))
        else $error("input register written with strobe low");

    input_steady_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (clear_n_sync && !(cs_rise && !sclk_sync && strobe_n_sync)) |=> $stable(st.input_regs))
        else $error("input register moved without a word");

    // strobe and clear
    strobe_copy_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (!strobe_n_sync && clear_n_sync) |=> st.dac_regs == st.input_regs)
        else $error("dac register not following input");

    strobe_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (strobe_n_sync && clear_n_sync) |=> $stable(st.dac_regs))
        else $error("dac register changed with strobe high");

    clear_zero_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !clear_n_sync |=> (st.dac_regs == 32'h0 && st.input_regs == 32'h0
        && ($past(shift_event) || $stable(st.shift_reg))))
        else $error("clear did not zero registers");

    // shutdown: drive enables change only with an accepted word
    all_down_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (cs_rise && !sclk_sync && strobe_n_sync && clear_n_sync && !st.shift_reg[11]) |=>
        o_dac_drive_en == 4'h0)
        else $error("shutdown all ignored");

    sel_down_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (cs_rise && !sclk_sync && strobe_n_sync && clear_n_sync && st.shift_reg[11:10] == 2'h2) |=>
        o_dac_drive_en == ~(4'h1 << $past(sel)))
        else $error("selected shutdown wrong");

    wake_up_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (cs_rise && !sclk_sync && strobe_n_sync && clear_n_sync && st.shift_reg[11:10] == 2'h3) |=>
        o_dac_drive_en == 4'hf)
        else $error("channels not restored");

    shutdown_keep_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !(cs_rise && !sclk_sync && strobe_n_sync && clear_n_sync) |=> $stable(o_dac_drive_en))
        else $error("shutdown state changed without a word");

    // main scenarios
    word_cover_c: cover property (@(posedge i_core_clk) cs_rise && !sclk_sync && strobe_n_sync && clear_n_sync);
    refused_cover_c: cover property (@(posedge i_core_clk) cs_rise && !strobe_n_sync);
    strobe_cover_c: cover property (@(posedge i_core_clk) !strobe_n_sync ##1 strobe_n_sync);
    clear_cover_c: cover property (@(posedge i_core_clk) !clear_n_sync);
    down_cover_c: cover property (@(posedge i_core_clk) o_dac_drive_en != 4'hf);
endmodule
`default_nettype wire

// [rtl/quad_dac_pkg.sv]
// Purpose: shared constants for the quad dac serial control block
// Assumes: 12-bit serial word, msb first, four 8-bit channels
// Notes: field positions index the received word
package quad_dac_pkg;
    localparam int WORD_BITS = 12;
    localparam int DATA_BITS = 8;
    localparam int CHANNELS = 4;
    localparam int SHUTDOWN_ALL_POS = 11;
    localparam int SHUTDOWN_SEL_POS = 10;
    localparam int CHAN_SEL_HIGH_POS = 9;
    localparam int CHAN_SEL_LOW_POS = 8;
    localparam int DATA_MSB_POS = 7;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [11:0] SHIFT_RESET = 12'h000;
    localparam logic [3:0] SHUTDOWN_RESET = 4'h0;
    localparam logic [2:0] SYNC_RESET = 3'h7;
    localparam logic [1:0] CTL_SYNC_RESET = 2'h3;
    localparam logic EDGE_PREV_RESET = 1'b1;
endpackage

// [test/host_link_model.sv]
// Purpose: host side of the three-wire link, sends 12-bit words
// Assumes: 64 ns link clock, called just after a core clock fall
// Notes: link clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
    // link pins driven towards the block
    output logic o_serial_clk,
    output logic o_chip_select_n,
    output logic o_data
);
    logic last;
    initial begin
        o_serial_clk = 1'b0;
        o_chip_select_n = 1'b1;
        o_data = 1'b0;
        last = 1'b0;
    end
    // data changes on the clock fall, well clear of the rise
    task automatic send_word(input logic [11:0] w);
        o_chip_select_n = 1'b0;
        #32;
        for (int i = 11; i >= 0; i--) begin
            o_data = w[i];
            last = w[i];
            #32 o_serial_clk = 1'b1;
            #32 o_serial_clk = 1'b0;
        end
        #32 o_chip_select_n = 1'b1; // rise with clock low
        #8 o_data = ~last; // released line must not keep the last bit
    endtask
endmodule
`default_nettype wire

// [test/test_quad_dac_serial_control.sv]
// Purpose: self-checking bench for the quad dac serial control block
// Assumes: host model drives the link, bench drives strobe and clear
// Notes: expected register image kept in exp_in
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module test_quad_dac_serial_control;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_dac_update_strobe_n = 1'b1;
    logic i_async_zero_clear_n = 1'b1;
    wire logic sclk, cs_n, sdata;
    logic [31:0] o_dac_value, o_input_value, exp_in, old_dac;
    logic [3:0] o_dac_drive_en;
    logic [11:0] o_shift_reg;
    int n_errors = 0;
    int comparisons = 0;
    always #4 i_core_clk = ~i_core_clk;
    host_link_model host (.o_serial_clk(sclk), .o_chip_select_n(cs_n), .o_data(sdata));
    quad_dac_serial_control DUT (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_serial_clk(sclk),
        .i_chip_select_n(cs_n), .i_serial_in_powerdown_pin(sdata),
        .i_dac_update_strobe_n(i_dac_update_strobe_n), .i_async_zero_clear_n(i_async_zero_clear_n),
        .o_dac_value(o_dac_value), .o_dac_drive_en(o_dac_drive_en),
        .o_input_value(o_input_value), .o_shift_reg(o_shift_reg));
    // one word, then let the sync and write stages settle; a low strobe or clear refuses it
    task automatic wr(input logic [11:0] w);
        host.send_word(w);
        repeat (8) @(negedge i_core_clk);
        if (i_dac_update_strobe_n && i_async_zero_clear_n)
            exp_in[w[9:8]*8 +: 8] = w[7:0];
    endtask
    task automatic test_done;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // watchdog, far beyond the nine words sent
    initial begin
        #100000;
        n_errors++;
        test_done();
    end
    initial begin
        exp_in = 32'h0000_0000;
        repeat (5) @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        @(negedge i_core_clk);
        for (int ch = 0; ch < 4; ch++)
            wr({2'b11, 2'(ch), 8'(8'h11 * (ch + 1))});
        `CHK(o_input_value, exp_in)
        `CHK(o_dac_value, 32'h0000_0000)
        `CHK(o_dac_drive_en, 4'hf)
        `CHK(o_shift_reg, 12'hf44)
        i_dac_update_strobe_n = 1'b0;
        repeat (8) @(negedge i_core_clk);
        `CHK(o_dac_value, exp_in)
        i_dac_update_strobe_n = 1'b1;
        repeat (8) @(negedge i_core_clk);
        old_dac = exp_in;
        wr(12'hca5);
        `CHK(o_input_value, exp_in)
        `CHK(o_dac_value, old_dac)
        wr(12'ha77);
        `CHK(o_dac_drive_en, 4'hb)
        wr(12'h433);
        `CHK(o_dac_drive_en, 4'h0)
        wr(12'hc33);
        `CHK(o_dac_drive_en, 4'hf)
        // strobe low at the select rise: word refused, dac stays transparent
        i_dac_update_strobe_n = 1'b0;
        wr(12'hd12);
        `CHK(o_input_value, exp_in)
        `CHK(o_dac_value, exp_in)
        i_dac_update_strobe_n = 1'b1;
        i_async_zero_clear_n = 1'b0;
        repeat (8) @(negedge i_core_clk);
        `CHK(o_input_value, 32'h0000_0000)
        `CHK(o_dac_value, 32'h0000_0000)
        `CHK(o_shift_reg, 12'hd12)
        i_async_zero_clear_n = 1'b1;
        test_done();
    end
endmodule
`default_nettype wire
